// *** shared/formatter_pkg.sv ***
// shared constants and types of the converter output formatter
package formatter_pkg;

  // ==========================================================
  // widths
  localparam int WORD_WIDTH    = 16;
  localparam int ADDR_WIDTH    = 8;
  localparam int DATA_WIDTH    = 32;
  localparam int EVENT_COUNT   = 3;
  localparam int SYNC_WIDTH    = 27;

  // ==========================================================
  // pipeline
  localparam int PIPE_LATENCY  = 7;

  // ==========================================================
  // clock figures
  localparam int CLK_PERIOD_NS  = 40;
  localparam int LINK_PERIOD_NS = 320;
  localparam int LINK_PERIOD_CYCLES = LINK_PERIOD_NS / CLK_PERIOD_NS;

  // ==========================================================
  // register byte offsets
  localparam logic [ADDR_WIDTH-1:0] STATUS_OFFSET = 8'h00;
  localparam logic [ADDR_WIDTH-1:0] MASK_OFFSET   = 8'h04;
  localparam logic [ADDR_WIDTH-1:0] STRAPS_OFFSET = 8'h08;

  // ==========================================================
  // status and mask bit positions
  localparam int FIRST_RANGE_BIT  = 0;
  localparam int SECOND_RANGE_BIT = 1;
  localparam int POWER_DOWN_BIT   = 2;

  // ==========================================================
  // values after reset
  localparam logic [EVENT_COUNT-1:0] STATUS_RESET = 3'h0;
  localparam logic [EVENT_COUNT-1:0] MASK_RESET   = 3'h0;
  localparam logic [WORD_WIDTH-1:0]  WORD_RESET   = 16'h0000;

  // ==========================================================
  // strap levels: ground, third, two thirds, full supply
  typedef enum logic [1:0] {
    OUT_FULL_CMOS  = 2'h0,
    OUT_DEMUX_CMOS = 2'h1,
    OUT_LVDS_LOW   = 2'h2,
    OUT_LVDS_STD   = 2'h3
  } output_mode_type;

  typedef enum logic [1:0] {
    FMT_OFFSET_STAB_OFF = 2'h0,
    FMT_OFFSET_STAB_ON  = 2'h1,
    FMT_TWOS_STAB_ON    = 2'h2,
    FMT_TWOS_STAB_OFF   = 2'h3
  } format_mode_type;

endpackage

// *** logic/level_sync.sv ***
// two flip-flop synchroniser for a group of outside levels
`timescale 1ns/10ps
`default_nettype none

module level_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  // ==========================================================
  // first stage is read by the second stage only
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

`default_nettype wire

// *** logic/event_regs.sv ***
// register slave with sticky status, mask and strap readback
`timescale 1ns/10ps
`default_nettype none

module event_regs
  import formatter_pkg::*;
(
  // clock and reset
  input  wire logic                               clk,
  input  wire logic                               reset,
  // register port
  input  wire logic [formatter_pkg::ADDR_WIDTH-1:0] addr,
  input  wire logic [formatter_pkg::DATA_WIDTH-1:0] wdata,
  input  wire logic                               write_strobe,
  input  wire logic                               read_strobe,
  output var  logic [formatter_pkg::DATA_WIDTH-1:0] rdata,
  // block side
  input  wire logic [formatter_pkg::EVENT_COUNT-1:0] event_pulse,
  input  wire logic [7:0]                         strap_view,
  output logic                                    irq
);

  // ==========================================================
  // decode
  logic [EVENT_COUNT-1:0] status_reg;
  logic [EVENT_COUNT-1:0] status_next;
  logic [EVENT_COUNT-1:0] mask_reg;
  logic [DATA_WIDTH-1:0]  read_value;

  wire hit_status = addr == STATUS_OFFSET;
  wire hit_mask   = addr == MASK_OFFSET;
  wire hit_straps = addr == STRAPS_OFFSET;
  wire [EVENT_COUNT-1:0] clear_bits =
    (write_strobe && hit_status) ? wdata[EVENT_COUNT-1:0] : '0;

  // a new event in the clearing cycle survives the clear
  assign status_next = (status_reg & ~clear_bits) | event_pulse;

  assign read_value =
    hit_status ? {{(DATA_WIDTH-EVENT_COUNT){1'b0}}, status_reg} :
    hit_mask   ? {{(DATA_WIDTH-EVENT_COUNT){1'b0}}, mask_reg} :
    hit_straps ? {24'h000000, strap_view} : '0;

  assign irq = |(status_reg & mask_reg);

  // ==========================================================
  // storage
  always_ff @(posedge clk) begin
    if (reset) begin
      status_reg <= STATUS_RESET;
      mask_reg   <= MASK_RESET;
      rdata      <= '0;
    end else begin
      status_reg <= status_next;
      if (write_strobe && hit_mask) begin
        mask_reg <= wdata[EVENT_COUNT-1:0];
      end
      rdata <= read_strobe ? read_value : '0;
    end
  end

endmodule

`default_nettype wire

// *** logic/cmos_output_formatter.sv ***
// cmos output stage: pipeline, format, scramble, demux, strobes
// ==========================================================
`timescale 1ns/10ps
`default_nettype none

module cmos_output_formatter
  import formatter_pkg::*;
(
  // clock and reset
  input  wire logic                                 clk,
  input  wire logic                                 reset,
  // encode clock pair, sampled by clk
  input  wire logic                                 encode_clock_pos,
  input  wire logic                                 encode_clock_neg,
  // conversion core result, offset binary
  input  wire logic [formatter_pkg::WORD_WIDTH-1:0] core_word,
  input  wire logic                                 core_out_of_range,
  // strap and control pins
  input  wire logic [1:0]                           output_mode_select,
  input  wire logic [1:0]                           format_select,
  input  wire logic                                 output_scramble_enable,
  input  wire logic                                 noise_inject_enable,
  input  wire logic                                 power_down_input,
  input  wire logic                                 gain_select,
  // first bus
  output var  logic [formatter_pkg::WORD_WIDTH-1:0] first_bus_word,
  output var  logic                                 first_bus_range_flag,
  output logic                                      first_bus_oe_n,
  // second bus
  output var  logic [formatter_pkg::WORD_WIDTH-1:0] second_bus_word,
  output var  logic                                 second_bus_range_flag,
  output logic                                      second_bus_oe_n,
  // data valid strobes
  output var  logic                                 valid_strobe,
  output logic                                      inverted_valid_strobe,
  output logic                                      strobe_oe_n,
  // analog controls
  output logic                                      analog_power_down,
  output logic                                      dither_active,
  output logic                                      gain_high_range,
  output logic                                      stabiliser_enable,
  output logic                                      lvds_selected,
  output logic                                      lvds_low_power,
  // register port
  input  wire logic [formatter_pkg::ADDR_WIDTH-1:0] addr,
  input  wire logic [formatter_pkg::DATA_WIDTH-1:0] wdata,
  input  wire logic                                 write_strobe,
  input  wire logic                                 read_strobe,
  output var  logic [formatter_pkg::DATA_WIDTH-1:0] rdata,
  output logic                                      irq
);

  // ==========================================================
  // synchronisers
  // every pin but clock, reset and the register port is outside the clk domain, including the core word,
  // which is latched by the encode clock; all take the same delay
  logic [SYNC_WIDTH-1:0] pins_raw;
  logic [SYNC_WIDTH-1:0] pins_sync;

  assign pins_raw = {
    encode_clock_pos,
    encode_clock_neg,
    power_down_input,
    noise_inject_enable,
    gain_select,
    output_scramble_enable,
    output_mode_select,
    format_select,
    core_out_of_range,
    core_word
  };

  level_sync #(
    .WIDTH (SYNC_WIDTH)
  ) pin_sync (
    .clk      (clk),
    .reset    (reset),
    .async_in (pins_raw),
    .sync_out (pins_sync)
  );

  wire                  enc_pos_s   = pins_sync[26];
  wire                  enc_neg_s   = pins_sync[25];
  wire                  power_down  = pins_sync[24];
  wire                  dither_s    = pins_sync[23];
  wire                  gain_s      = pins_sync[22];
  wire                  scramble_s  = pins_sync[21];
  wire [1:0]            mode_s      = pins_sync[20:19];
  wire [1:0]            format_s    = pins_sync[18:17];
  wire                  range_s     = pins_sync[16];
  wire [WORD_WIDTH-1:0] word_s      = pins_sync[15:0];

  // ==========================================================
  // encode edges
  logic enc_prev_reg;
  logic pd_prev_reg;

  wire enc_level = enc_pos_s & ~enc_neg_s;
  wire enc_rise  = enc_level & ~enc_prev_reg;
  wire enc_fall  = ~enc_level & enc_prev_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      enc_prev_reg <= 1'b0;
      pd_prev_reg  <= 1'b0;
    end else begin
      enc_prev_reg <= enc_level;
      pd_prev_reg  <= power_down;
    end
  end

  // ==========================================================
  // strap decode
  output_mode_type out_mode;
  format_mode_type fmt_mode;

  assign out_mode = output_mode_type'(mode_s);
  assign fmt_mode = format_mode_type'(format_s);

  wire demux_mode = out_mode == OUT_DEMUX_CMOS;
  wire twos_comp  = (fmt_mode == FMT_TWOS_STAB_ON) ||
                    (fmt_mode == FMT_TWOS_STAB_OFF);

  assign lvds_selected     = (out_mode == OUT_LVDS_LOW) ||
                             (out_mode == OUT_LVDS_STD);
  assign lvds_low_power    = out_mode == OUT_LVDS_LOW;
  assign stabiliser_enable = (fmt_mode == FMT_OFFSET_STAB_ON) ||
                             (fmt_mode == FMT_TWOS_STAB_ON);
  assign analog_power_down = power_down;
  assign dither_active     = dither_s;
  assign gain_high_range   = gain_s;

  // ==========================================================
  // pipeline of seven encode cycles, word and flag side by side
  logic [WORD_WIDTH:0] stage_reg [PIPE_LATENCY];

  generate
    for (genvar i = 0; i < PIPE_LATENCY; i++) begin : g_stage
      if (i == 0) begin : g_first
        always_ff @(posedge clk) begin
          if (reset) begin
            stage_reg[i] <= '0;
          end else if (enc_rise) begin
            stage_reg[i] <= {range_s, word_s};
          end
        end
      end else begin : g_rest
        always_ff @(posedge clk) begin
          if (reset) begin
            stage_reg[i] <= '0;
          end else if (enc_rise) begin
            stage_reg[i] <= stage_reg[i-1];
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // number format and scrambling
  // scrambling spreads output switching; receiver must xor back
  logic [WORD_WIDTH-1:0] coded_word;
  logic [WORD_WIDTH-1:0] sent_word;
  logic                  sent_range;

  assign sent_range = stage_reg[PIPE_LATENCY-1][WORD_WIDTH];
  assign coded_word = twos_comp ?
    {~stage_reg[PIPE_LATENCY-1][WORD_WIDTH-1],
     stage_reg[PIPE_LATENCY-1][WORD_WIDTH-2:0]} :
    stage_reg[PIPE_LATENCY-1][WORD_WIDTH-1:0];
  // the lsb itself is sent plain, so the far end can undo it
  assign sent_word = scramble_s ?
    {coded_word[WORD_WIDTH-1:1] ^ {(WORD_WIDTH-1){coded_word[0]}},
     coded_word[0]} :
    coded_word;

  // ==========================================================
  // bus update and strobe sequencing
  logic                  phase_reg;
  logic [WORD_WIDTH-1:0] pending_word_reg;
  logic                  pending_range_reg;

  wire full_update  = enc_rise & ~demux_mode;
  wire pair_first   = enc_rise & demux_mode & ~phase_reg;
  wire pair_second  = enc_rise & demux_mode & phase_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      phase_reg <= 1'b0;
    end else if (!demux_mode) begin
      phase_reg <= 1'b0;
    end else if (enc_rise) begin
      phase_reg <= ~phase_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pending_word_reg  <= WORD_RESET;
      pending_range_reg <= 1'b0;
    end else if (pair_first) begin
      pending_word_reg  <= sent_word;
      pending_range_reg <= sent_range;
    end
  end

  // first bus: every word in full rate, the older of a pair in demux
  always_ff @(posedge clk) begin
    if (reset) begin
      first_bus_word       <= WORD_RESET;
      first_bus_range_flag <= 1'b0;
    end else if (full_update) begin
      first_bus_word       <= sent_word;
      first_bus_range_flag <= sent_range;
    end else if (pair_second) begin
      first_bus_word       <= pending_word_reg;
      first_bus_range_flag <= pending_range_reg;
    end
  end

  // second bus: the newer word of a pair, only in demux
  always_ff @(posedge clk) begin
    if (reset) begin
      second_bus_word       <= WORD_RESET;
      second_bus_range_flag <= 1'b0;
    end else if (pair_second) begin
      second_bus_word       <= sent_word;
      second_bus_range_flag <= sent_range;
    end
  end

  // full rate: high from encode rise to encode fall;
  // demux: high for one encode cycle, low the next, so the
  // falling edge lands a whole encode cycle after the update
  always_ff @(posedge clk) begin
    if (reset) begin
      valid_strobe <= 1'b0;
    end else if (full_update || pair_second) begin
      valid_strobe <= 1'b1;
    end else if (pair_first || (enc_fall && !demux_mode)) begin
      valid_strobe <= 1'b0;
    end
  end

  assign inverted_valid_strobe = ~valid_strobe;

  // ==========================================================
  // output enables, low while driving
  assign first_bus_oe_n  = power_down;
  assign strobe_oe_n     = power_down;
  assign second_bus_oe_n = power_down | ~demux_mode;

  // ==========================================================
  // events and register slave
  logic [EVENT_COUNT-1:0] event_pulse;
  logic [7:0]             strap_view;

  assign event_pulse[FIRST_RANGE_BIT] =
    (full_update & sent_range) | (pair_second & pending_range_reg);
  assign event_pulse[SECOND_RANGE_BIT] = pair_second & sent_range;
  assign event_pulse[POWER_DOWN_BIT]   = power_down & ~pd_prev_reg;

  assign strap_view = {
    scramble_s,
    gain_s,
    dither_s,
    power_down,
    format_s,
    mode_s
  };

  event_regs regs (
    .clk          (clk),
    .reset        (reset),
    .addr         (addr),
    .wdata        (wdata),
    .write_strobe (write_strobe),
    .read_strobe  (read_strobe),
    .rdata        (rdata),
    .event_pulse  (event_pulse),
    .strap_view   (strap_view),
    .irq          (irq)
  );

endmodule

`default_nettype wire

// *** tb/formatter_assertions.sv ***
// concurrent checks on the pins of the cmos output formatter
`timescale 1ns/10ps
`default_nettype none

module formatter_assertions (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // straps and output pins
  input wire logic [1:0]  output_mode_select,
  input wire logic        power_down_input,
  input wire logic [15:0] first_bus_word,
  input wire logic        first_bus_range_flag,
  input wire logic        first_bus_oe_n,
  input wire logic [15:0] second_bus_word,
  input wire logic        second_bus_oe_n,
  input wire logic        valid_strobe,
  input wire logic        inverted_valid_strobe,
  input wire logic        strobe_oe_n,
  // register port
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        write_strobe,
  input wire logic        read_strobe,
  input wire logic [31:0] rdata,
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // ==========================================================
  // output enables
  // pins cross two flip-flops, so a level needs three samples to show
  property p_b_float;
    (output_mode_select == 2'h0) [*3] |-> second_bus_oe_n;
  endproperty
  a_b_float: assert property (p_b_float)
    else $error("second bus driven in full rate mode");
  property p_b_drive;
    (output_mode_select == 2'h1 && !power_down_input) [*3]
      |-> !second_bus_oe_n;
  endproperty
  a_b_drive: assert property (p_b_drive)
    else $error("second bus not driven in demux mode");
  property p_pd_float;
    power_down_input [*3]
      |-> first_bus_oe_n && second_bus_oe_n && strobe_oe_n;
  endproperty
  a_pd_float: assert property (p_pd_float)
    else $error("outputs driven while powered down");
  property p_a_drive;
    (!power_down_input) [*3] |-> !first_bus_oe_n && !strobe_oe_n;
  endproperty
  a_a_drive: assert property (p_a_drive)
    else $error("first bus not driven");

  // ==========================================================
  // strobes and word timing
  property p_inv;
    inverted_valid_strobe == !valid_strobe;
  endproperty
  a_inv: assert property (p_inv)
    else $error("inverted strobe is not the complement");
  property p_full_step;
    (output_mode_select == 2'h0) [*3] ##0 $changed(first_bus_word)
      |-> $rose(valid_strobe);
  endproperty
  a_full_step: assert property (p_full_step)
    else $error("full rate word moved without strobe rise");
  property p_demux_step;
    (output_mode_select == 2'h1) [*3] ##0 $changed(second_bus_word)
      |-> $rose(valid_strobe);
  endproperty
  a_demux_step: assert property (p_demux_step)
    else $error("demux word moved without strobe rise");
  property p_flag_step;
    $changed(first_bus_range_flag) |-> $changed(valid_strobe);
  endproperty
  a_flag_step: assert property (p_flag_step)
    else $error("range flag moved apart from its word");

  // ==========================================================
  // register port
  property p_read_once;
    !read_strobe |=> rdata == 32'h0;
  endproperty
  a_read_once: assert property (p_read_once)
    else $error("read data outside its cycle");
  property p_mask_all;
    write_strobe && addr == 8'h04 && wdata[2:0] == 3'h0 |=> !irq;
  endproperty
  a_mask_all: assert property (p_mask_all)
    else $error("interrupt with every event masked");

  c_demux: cover property (!second_bus_oe_n);
  c_irq: cover property ($rose(irq));
  c_pd: cover property (power_down_input [*3]);
endmodule
`default_nettype wire

// *** tb/capture_receiver.sv ***
// far side model: receiver latching both buses on the strobe edge
`timescale 1ns/10ps
`default_nettype none

module capture_receiver (
  // pins from the converter, and its scramble strap
  input  wire logic        inverted_valid_strobe,
  input  wire logic        strobe_oe_n,
  input  wire logic [15:0] first_bus_word,
  input  wire logic        first_bus_range_flag,
  input  wire logic [15:0] second_bus_word,
  input  wire logic        second_bus_range_flag,
  input  wire logic        descramble,
  // captured samples
  output var  logic [15:0] got_first,
  output var  logic [15:0] got_second,
  output var  logic [1:0]  got_flags,
  output var  int          got_count
);
  function automatic logic [15:0] clean(input logic [15:0] v);
    clean = descramble ? v ^ {{15{v[0]}}, 1'b0} : v;
  endfunction

  initial got_count = 0;

  // ==========================================================
  // latch on the inverted strobe's rise, a step late so that
  // updates made at the same clock edge have landed
  always @(posedge inverted_valid_strobe) begin
    #1;
    if (!strobe_oe_n) begin
      got_first  = clean(first_bus_word);
      got_second = clean(second_bus_word);
      got_flags  = {second_bus_range_flag, first_bus_range_flag};
      got_count  = got_count + 1;
    end
  end
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for the cmos output formatter
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import formatter_pkg::*;
  // ==========================================================
  // signals
  logic        clk, reset, encode_clock_pos, encode_clock_neg;
  logic [15:0] core_word, first_bus_word, second_bus_word;
  logic [1:0]  output_mode_select, format_select;
  logic        core_out_of_range, output_scramble_enable;
  logic        noise_inject_enable, power_down_input, gain_select;
  logic        first_bus_range_flag, first_bus_oe_n;
  logic        second_bus_range_flag, second_bus_oe_n;
  logic        valid_strobe, inverted_valid_strobe, strobe_oe_n;
  logic        analog_power_down, dither_active, gain_high_range;
  logic        stabiliser_enable, lvds_selected, lvds_low_power;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata;
  logic        write_strobe, read_strobe, irq;
  logic        rd_d = 1'b0;
  logic [15:0] got_first, got_second;
  logic [1:0]  got_flags;
  logic [33:0] seen, want;
  int          got_count, rises;
  int          n_fail = 0;
  int          check_count = 0;
  logic [33:0] exp_q[$];
  logic [31:0] rd_q[$];
  wire  [4:0]  strap_out = {dither_active, gain_high_range,
                            stabiliser_enable, lvds_selected, lvds_low_power};

  cmos_output_formatter dut (
    .clk, .reset, .encode_clock_pos, .encode_clock_neg, .core_word,
    .core_out_of_range, .output_mode_select, .format_select,
    .output_scramble_enable, .noise_inject_enable, .power_down_input,
    .gain_select, .first_bus_word, .first_bus_range_flag, .first_bus_oe_n,
    .second_bus_word, .second_bus_range_flag, .second_bus_oe_n,
    .valid_strobe, .inverted_valid_strobe, .strobe_oe_n, .analog_power_down,
    .dither_active, .gain_high_range, .stabiliser_enable, .lvds_selected,
    .lvds_low_power, .addr, .wdata, .write_strobe, .read_strobe, .rdata, .irq
  );

  capture_receiver rx (
    .inverted_valid_strobe, .strobe_oe_n, .first_bus_word,
    .first_bus_range_flag, .second_bus_word, .second_bus_range_flag,
    .descramble(output_scramble_enable), .got_first, .got_second,
    .got_flags, .got_count
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ==========================================================
  // comparison, register access and verdict
  task automatic check(input logic [33:0] s, input logic [33:0] e);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, s, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr         <= a;
    wdata        <= d;
    write_strobe <= 1'b1;
    @(posedge clk);
    write_strobe <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr        <= a;
    read_strobe <= 1'b1;
    rd_q.push_back(e);
    @(posedge clk);
    read_strobe <= 1'b0;
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_d)
      check({2'b0, rdata}, {2'b0, rd_q.pop_front()});
    rd_d = read_strobe;
  end

  // captures holding only pipeline fill words are skipped by counting encode rises
  always @(got_count) begin
    if (rises >= ((output_mode_select == 2'h1) ? 9 : 8)) begin
      if (output_mode_select == 2'h1)
        seen = {got_flags, got_second, got_first};
      else
        seen = {1'b0, got_flags[0], 16'h0, got_first};
      want = exp_q.size() > 0 ? exp_q.pop_front() : ~seen;
      check(seen, want);
    end
  end

  // ==========================================================
  // one run of encode cycles under one set of straps
  task automatic phase(input logic [1:0] m, input logic [1:0] f,
                       input logic s, input int n);
    logic [15:0] w, pw, mx;
    logic        o, po, d, g;
    logic [4:0]  st;
    int          c0, nc;
    d  = 1'($urandom);
    g  = 1'($urandom);
    st = {d, g, f == 2'h1 || f == 2'h2, m[1], m == 2'h2};
    // full rate strobes once a word, demux once a pair but the last
    nc = (m == 2'h1) ? n / 2 - 1 : n;
    mx = {f[1], 15'h0};
    pw = 16'h0;
    po = 1'b0;
    // cleared ahead of reset, so the capture that reset causes is skipped
    exp_q.delete();
    rises = 0;
    output_mode_select     <= m;
    format_select          <= f;
    output_scramble_enable <= s;
    noise_inject_enable    <= d;
    gain_select            <= g;
    reset                  <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    c0 = got_count;
    repeat (3) @(posedge clk);
    check({29'h0, strap_out}, {29'h0, st});
    for (int i = 1; i <= n; i++) begin
      w = 16'($urandom);
      o = (i == 1) | 1'($urandom);
      core_word         <= w;
      core_out_of_range <= o;
      repeat (4) @(posedge clk);
      encode_clock_pos <= 1'b1;
      encode_clock_neg <= 1'b0;
      rises++;
      if (m != 2'h1)
        exp_q.push_back({1'b0, o, 16'h0, w ^ mx});
      // pairs open with the fill word ahead of sample one
      else if (i % 2 == 1)
        exp_q.push_back({o, po, w ^ mx, pw ^ mx});
      pw = w;
      po = o;
      repeat (4) @(posedge clk);
      encode_clock_pos <= 1'b0;
      encode_clock_neg <= 1'b1;
    end
    repeat (12) @(posedge clk);
    check(34'(got_count - c0), 34'(nc));
  endtask

  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'h9bd5));
    {reset, encode_clock_neg} = 2'h3;
    {encode_clock_pos, core_word, core_out_of_range} = 18'h0;
    {output_mode_select, format_select, output_scramble_enable} = 5'h0;
    {noise_inject_enable, power_down_input, gain_select} = 3'h0;
    {addr, wdata, write_strobe, read_strobe} = 42'h0;
    // the first phase holds reset for the last two of the twenty
    repeat (18) @(posedge clk);
    phase(2'h0, 2'h0, 1'b0, 24);
    rd(STATUS_OFFSET, 32'h1);
    @(posedge clk);
    check({33'h0, irq}, 34'h0);
    wr(MASK_OFFSET, 32'h1);
    @(posedge clk);
    check({33'h0, irq}, 34'h1);
    wr(STATUS_OFFSET, 32'h1);
    wr(8'h0c, 32'h7);
    rd(MASK_OFFSET, 32'h1);
    rd(8'h0c, 32'h0);
    rd(STATUS_OFFSET, 32'h0);
    rd(STRAPS_OFFSET, {24'h0, output_scramble_enable, gain_select,
                       noise_inject_enable, power_down_input,
                       format_select, output_mode_select});
    check({33'h0, irq}, 34'h0);
    phase(2'h1, 2'h1, 1'b1, 24);
    phase(2'h2, 2'h2, 1'b0, 16);
    phase(2'h3, 2'h3, 1'b1, 16);
    power_down_input <= 1'b1;
    repeat (4) @(posedge clk);
    check({30'h0, analog_power_down, first_bus_oe_n, second_bus_oe_n,
           strobe_oe_n}, 34'hf);
    wr(MASK_OFFSET, 32'h4);
    @(posedge clk);
    check({33'h0, irq}, 34'h1);
    wr(MASK_OFFSET, 32'h0);
    @(posedge clk);
    check({33'h0, irq}, 34'h0);
    repeat (3) @(posedge clk);
    results();
  end

  // the full run takes about 30 us; allow several times that
  initial begin
    #200000;
    n_fail++;
    results();
  end
endmodule

bind cmos_output_formatter formatter_assertions chk (
  .clk, .reset, .output_mode_select, .power_down_input, .first_bus_word,
  .first_bus_range_flag, .first_bus_oe_n, .second_bus_word,
  .second_bus_oe_n, .valid_strobe, .inverted_valid_strobe, .strobe_oe_n,
  .addr, .wdata, .write_strobe, .read_strobe, .rdata, .irq
);
`default_nettype wire
